/* File: dac_cmd_pkg.sv */
`default_nettype none
package dac_cmd_pkg;

    localparam int FRAME_BITS = 16;
    localparam int CHANNELS = 8;
    localparam int CODE_W = 8;
    localparam int ADDR_W = 3;
    localparam int SYNC_STAGES = 3;

    // frame field positions, counted from the last bit shifted in
    localparam int PAYLOAD_LSB = 0;
    localparam int CODE_LSB = 8;
    localparam int ADDR_LSB = 11;
    localparam int ADDR_TOP_BIT = 2;

    localparam logic [CODE_W-1:0] CODE_RESET = 8'h00;
    localparam logic [CHANNELS-1:0] BUFFER_ENABLE_RESET = 8'hff;
    localparam logic [FRAME_BITS-1:0] SHIFT_RESET = 16'h0000;
    localparam logic PHASE_FALLING = 1'b0;
    localparam logic PHASE_RISING = 1'b1;
    localparam logic PHASE_RESET = PHASE_FALLING;

    typedef enum logic [2:0] {
        CMD_NOP = 3'h0,
        CMD_CLEAR = 3'h1,
        CMD_SHUTDOWN = 3'h2,
        CMD_PHASE = 3'h3,
        CMD_LOAD_ALL = 3'h4,
        CMD_LOAD_INPUT = 3'h5,
        CMD_LOAD_BOTH = 3'h6,
        CMD_TRANSFER = 3'h7
    } cmd_code_t;

    typedef struct packed {
        logic [1:0] ignored;
        logic [ADDR_W-1:0] channel_address_bits;
        cmd_code_t command_code_bits;
        logic [CODE_W-1:0] payload_bits;
    } frame_t;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic sdin;
        logic load_strobe_n;
    } pins_t;

    // idle levels of the pins: select high, clock low, data low, strobe high
    localparam pins_t PINS_IDLE = 4'h9;

endpackage
`default_nettype wire

/* File: pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync
    import dac_cmd_pkg::*;
#(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // pins and their filtered levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] filtered
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage1 <= RESET_VALUE;
            stage2 <= RESET_VALUE;
            stage3 <= RESET_VALUE;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // a level counts only once two later stages agree, which drops one-cycle glitches
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            filtered <= RESET_VALUE;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    filtered[i] <= stage3[i];
                end
            end
        end
    end

endmodule
`default_nettype wire

/* File: channel_cell.sv */
`timescale 1ns/1ps
`default_nettype none
module channel_cell
    import dac_cmd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // one-cycle commands, the strobe level and the data
    input wire logic clear,
    input wire logic write_input,
    input wire logic load_direct,
    input wire logic transfer,
    input wire logic transparent,
    input wire logic [CODE_W-1:0] data,
    // held codes
    output logic [CODE_W-1:0] input_value,
    output logic [CODE_W-1:0] dac_value
);

    logic [CODE_W-1:0] next_input;

    always_comb begin
        next_input = input_value;
        if (clear) begin
            next_input = CODE_RESET;
        end else if (write_input) begin
            next_input = data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            input_value <= CODE_RESET;
        end else begin
            input_value <= next_input;
        end
    end

    // transparency uses the new input value so an update reaches the output in the same cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dac_value <= CODE_RESET;
        end else if (clear) begin
            dac_value <= CODE_RESET;
        end else if (load_direct) begin
            dac_value <= data;
        end else if (transfer || transparent) begin
            dac_value <= next_input;
        end
    end

endmodule
`default_nettype wire

/* File: octal_dac_command_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module octal_dac_command_decoder
    import dac_cmd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // serial link pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdin,
    output logic sdout,
    // hardware load strobe
    input wire logic load_strobe_n,
    // channel codes
    output logic [CHANNELS-1:0][CODE_W-1:0] dac_code,
    output logic [CHANNELS-1:0][CODE_W-1:0] input_code,
    // power and phase state
    output logic [CHANNELS-1:0] buffer_enable,
    output logic full_powerdown,
    output logic rising_phase
);

    ////////////////////////////////////////////////////////////////////////////////
    // pin sampling

    pins_t raw_pins;
    pins_t pin_f;
    logic [$bits(pins_t)-1:0] pin_f_bits;
    logic sclk_prev;
    logic cs_n_prev;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_active;
    logic frame_end;

    assign raw_pins = {cs_n, sclk, sdin, load_strobe_n};
    assign pin_f = pins_t'(pin_f_bits);

    pin_sync #(
        .WIDTH($bits(pins_t)),
        .RESET_VALUE(PINS_IDLE)
    ) u_pin_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in(raw_pins),
        .filtered(pin_f_bits)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclk_prev <= PINS_IDLE.sclk;
            cs_n_prev <= PINS_IDLE.cs_n;
        end else begin
            sclk_prev <= pin_f.sclk;
            cs_n_prev <= pin_f.cs_n;
        end
    end

    assign sclk_rise = pin_f.sclk & ~sclk_prev;
    assign sclk_fall = ~pin_f.sclk & sclk_prev;
    assign cs_active = ~pin_f.cs_n;
    assign frame_end = pin_f.cs_n & ~cs_n_prev;

    ////////////////////////////////////////////////////////////////////////////////
    // shift register and serial output

    logic [FRAME_BITS-1:0] shift;
    logic spill;
    frame_t frame;

    // msb arrives first, so after sixteen edges it sits at the top
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shift <= SHIFT_RESET;
        end else if (cs_active && sclk_rise) begin
            shift <= {shift[FRAME_BITS-2:0], pin_f.sdin};
        end
    end

    // the bit leaving the register, held for the falling-edge launch half a clock later
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            spill <= 1'b0;
        end else if (cs_active && sclk_rise) begin
            spill <= shift[FRAME_BITS-1];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sdout <= 1'b0;
        end else if (cs_active) begin
            if (rising_phase && sclk_rise) begin
                sdout <= shift[FRAME_BITS-1];
            end else if (!rising_phase && sclk_fall) begin
                sdout <= spill;
            end
        end
    end

    assign frame = frame_t'(shift);

    ////////////////////////////////////////////////////////////////////////////////
    // command decode at select rise

    logic do_clear;
    logic do_shutdown;
    logic do_phase;
    logic do_load_all;
    logic do_load_input;
    logic do_load_both;
    logic do_transfer;
    logic wake;

    // decoding waits for the select rise so a frame never acts while it is still shifting in
    always_comb begin
        do_clear = 1'b0;
        do_shutdown = 1'b0;
        do_phase = 1'b0;
        do_load_all = 1'b0;
        do_load_input = 1'b0;
        do_load_both = 1'b0;
        do_transfer = 1'b0;
        if (frame_end) begin
            case (frame.command_code_bits)
                CMD_NOP: begin
                    do_clear = 1'b0;
                end
                CMD_CLEAR: begin
                    do_clear = 1'b1;
                end
                CMD_SHUTDOWN: begin
                    do_shutdown = 1'b1;
                end
                CMD_PHASE: begin
                    do_phase = 1'b1;
                    do_transfer = 1'b1;
                end
                CMD_LOAD_ALL: begin
                    do_load_all = 1'b1;
                end
                CMD_LOAD_INPUT: begin
                    do_load_input = 1'b1;
                end
                CMD_LOAD_BOTH: begin
                    do_load_both = 1'b1;
                end
                CMD_TRANSFER: begin
                    do_transfer = 1'b1;
                end
                default: begin
                    do_clear = 1'b0;
                end
            endcase
        end
    end

    assign wake = do_clear | do_load_all | do_load_both;

    ////////////////////////////////////////////////////////////////////////////////
    // channels

    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
        logic hit;
        assign hit = (frame.channel_address_bits == ADDR_W'(ch));
        channel_cell u_cell (
            .clk(clk),
            .resetn(resetn),
            .clear(do_clear),
            .write_input((do_load_input | do_load_both) & hit),
            .load_direct(do_load_all | (do_load_both & hit)),
            .transfer(do_transfer),
            .transparent(~pin_f.load_strobe_n),
            .data(frame.payload_bits),
            .input_value(input_code[ch]),
            .dac_value(dac_code[ch])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // shutdown and phase

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            buffer_enable <= BUFFER_ENABLE_RESET;
            full_powerdown <= 1'b0;
        end else if (do_shutdown) begin
            buffer_enable <= frame.payload_bits;
            full_powerdown <= (frame.payload_bits == CODE_RESET);
        end else if (wake) begin
            buffer_enable <= BUFFER_ENABLE_RESET;
            full_powerdown <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rising_phase <= PHASE_RESET;
        end else if (do_phase) begin
            rising_phase <= frame.channel_address_bits[ADDR_TOP_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    property p_nop;
        @(posedge clk) disable iff (!resetn)
        frame_end && frame.command_code_bits == CMD_NOP && pin_f.load_strobe_n
        |=> $stable(dac_code) && $stable(input_code);
    endproperty
    a_nop: assert property (p_nop) else $error("no-op changed a register");

    property p_clear;
        @(posedge clk) disable iff (!resetn)
        do_clear |=> dac_code == '0 && input_code == '0 && !full_powerdown;
    endproperty
    a_clear: assert property (p_clear) else $error("clear left a nonzero code");

    property p_shutdown;
        @(posedge clk) disable iff (!resetn)
        do_shutdown |=> buffer_enable == $past(frame.payload_bits)
            && full_powerdown == ($past(frame.payload_bits) == CODE_RESET);
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown mask wrong");

    property p_wake_only;
        @(posedge clk) disable iff (!resetn)
        !do_shutdown && !wake |=> $stable(buffer_enable) && $stable(full_powerdown);
    endproperty
    a_wake_only: assert property (p_wake_only) else $error("shutdown left unexpectedly");

    property p_phase;
        @(posedge clk) disable iff (!resetn)
        do_phase |=> rising_phase == $past(frame.channel_address_bits[ADDR_TOP_BIT])
            && dac_code == $past(input_code);
    endproperty
    a_phase: assert property (p_phase) else $error("phase command wrong");

    property p_phase_hold;
        @(posedge clk) disable iff (!resetn)
        !do_phase |=> $stable(rising_phase);
    endproperty
    a_phase_hold: assert property (p_phase_hold) else $error("phase changed");

    property p_load_all;
        @(posedge clk) disable iff (!resetn)
        do_load_all |=> dac_code == {CHANNELS{$past(frame.payload_bits)}}
            && $stable(input_code);
    endproperty
    a_load_all: assert property (p_load_all) else $error("load-all wrong");

    property p_load_input;
        @(posedge clk) disable iff (!resetn)
        do_load_input && pin_f.load_strobe_n
        |=> input_code[$past(frame.channel_address_bits)] == $past(frame.payload_bits)
            && $stable(dac_code);
    endproperty
    a_load_input: assert property (p_load_input) else $error("preload wrong");

    property p_load_both;
        @(posedge clk) disable iff (!resetn)
        do_load_both
        |=> dac_code[$past(frame.channel_address_bits)] == $past(frame.payload_bits)
            && input_code[$past(frame.channel_address_bits)] == $past(frame.payload_bits);
    endproperty
    a_load_both: assert property (p_load_both) else $error("load-both wrong");

    property p_transfer;
        @(posedge clk) disable iff (!resetn)
        do_transfer |=> dac_code == $past(input_code);
    endproperty
    a_transfer: assert property (p_transfer) else $error("transfer wrong");

    property p_transparent;
        @(posedge clk) disable iff (!resetn)
        !pin_f.load_strobe_n && !frame_end |=> dac_code == input_code;
    endproperty
    a_transparent: assert property (p_transparent) else $error("strobe not transparent");

    property p_hold_out;
        @(posedge clk) disable iff (!resetn)
        pin_f.cs_n |=> $stable(sdout);
    endproperty
    a_hold_out: assert property (p_hold_out) else $error("output moved while idle");

    property p_quiet_frame;
        @(posedge clk) disable iff (!resetn)
        cs_active && pin_f.load_strobe_n |=> $stable(dac_code) && $stable(input_code);
    endproperty
    a_quiet_frame: assert property (p_quiet_frame) else $error("acted inside a frame");

endmodule
`default_nettype wire

/* File: spi_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_master_model
    import dac_cmd_pkg::*;
(
    // timing
    input wire logic clk,
    // link pins
    output logic cs_n,
    output logic sclk,
    output logic sdin,
    input wire logic sdout
);
    // sdout sampled just before each sclk rise, oldest bit at the top
    logic [FRAME_BITS-1:0] captured;

    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdin = 1'b0;
        captured = '0;
    end

    // half an 800 ns link period
    task automatic half();
        repeat (4) @(negedge clk);
    endtask

    task automatic open_frame();
        cs_n <= 1'b0;
        half();
    endtask

    // msb first, data changes while sclk is low
    task automatic shift_word(input logic [FRAME_BITS-1:0] w);
        for (int i = FRAME_BITS - 1; i >= 0; i--) begin
            sdin <= w[i];
            half();
            captured <= {captured[FRAME_BITS-2:0], sdout};
            sclk <= 1'b1;
            half();
            sclk <= 1'b0;
        end
    endtask

    // released data line shows the inverse, so a stale bit cannot pass
    task automatic close_frame();
        half();
        cs_n <= 1'b1;
        sdin <= ~sdin;
        repeat (10) @(negedge clk);
    endtask
endmodule
`default_nettype wire

/* File: octal_dac_command_decoder_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module octal_dac_command_decoder_tb
    import dac_cmd_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic load_strobe_n = 1'b1;
    wire logic cs_n;
    wire logic sclk;
    wire logic sdin;
    logic sdout;
    logic [CHANNELS-1:0][CODE_W-1:0] dac_code;
    logic [CHANNELS-1:0][CODE_W-1:0] input_code;
    logic [CHANNELS-1:0] buffer_enable;
    logic full_powerdown;
    logic rising_phase;
    int err_count = 0;
    int tests_run = 0;

    always #50 clk = ~clk;

    octal_dac_command_decoder u_octal_dac_command_decoder (
        .clk(clk), .resetn(resetn), .cs_n(cs_n), .sclk(sclk), .sdin(sdin),
        .sdout(sdout), .load_strobe_n(load_strobe_n), .dac_code(dac_code),
        .input_code(input_code), .buffer_enable(buffer_enable),
        .full_powerdown(full_powerdown), .rising_phase(rising_phase)
    );

    spi_master_model u_spi_master_model (
        .clk(clk), .cs_n(cs_n), .sclk(sclk), .sdin(sdin), .sdout(sdout)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("counts: %0d checks, %0d mismatches", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ignored bits set to ones so a misplaced field shows up
    function automatic logic [15:0] word_of(input logic [2:0] a, input cmd_code_t c,
                                            input logic [7:0] d);
        return {2'b11, a, c, d};
    endfunction

    task automatic cmd(input logic [2:0] a, input cmd_code_t c, input logic [7:0] d);
        u_spi_master_model.open_frame();
        u_spi_master_model.shift_word(word_of(a, c, d));
        u_spi_master_model.close_frame();
    endtask

    task automatic chk_ch(input int i, input logic [7:0] ei, input logic [7:0] ed);
        chk("input_code", {8'h00, ei}, {8'h00, input_code[i]});
        chk("dac_code", {8'h00, ed}, {8'h00, dac_code[i]});
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int i = 0; i < CHANNELS; i++) begin
            chk_ch(i, 8'h00, 8'h00);
        end
        chk("buffer_enable", 16'h00ff, {8'h00, buffer_enable});
        chk_bit("full_powerdown", 1'b0, full_powerdown);
        chk_bit("rising_phase", 1'b0, rising_phase);
        $display("test reset done");
    endtask

    task automatic t_load_input();
        for (int i = 0; i < CHANNELS; i++) begin
            u_spi_master_model.open_frame();
            u_spi_master_model.shift_word(word_of(3'(i), CMD_LOAD_INPUT, 8'h10 + 8'(i)));
            chk_ch(i, 8'h00, 8'h00);
            u_spi_master_model.close_frame();
            chk_ch(i, 8'h10 + 8'(i), 8'h00);
        end
        cmd(3'd0, CMD_TRANSFER, 8'h00);
        for (int i = 0; i < CHANNELS; i++) begin
            chk_ch(i, 8'h10 + 8'(i), 8'h10 + 8'(i));
        end
        $display("test load and transfer done");
    endtask

    // far word first, then a no-op for this device
    task automatic t_chain(input logic rising);
        logic [15:0] w1;
        w1 = word_of(3'd0, CMD_LOAD_BOTH, 8'hef);
        u_spi_master_model.open_frame();
        u_spi_master_model.shift_word(w1);
        u_spi_master_model.shift_word(word_of(3'd7, CMD_NOP, 8'hff));
        u_spi_master_model.close_frame();
        chk_ch(0, 8'h10, 8'h10);
        // sdout is registered at each sclk rise, so it lags one sample; the pin filter makes the falling phase lag one bit more
        if (rising) begin
            chk("sdout stream", {1'b0, w1[15:1]}, {1'b0, u_spi_master_model.captured[14:0]});
        end else begin
            chk("sdout stream", {2'b00, w1[15:2]}, {2'b00, u_spi_master_model.captured[13:0]});
        end
        repeat (20) @(negedge clk);
        chk_bit("sdout", w1[0], sdout);
        $display("test chain done");
    endtask

    task automatic t_strobe();
        @(negedge clk);
        load_strobe_n = 1'b0;
        cmd(3'd1, CMD_LOAD_INPUT, 8'h3c);
        chk_ch(1, 8'h3c, 8'h3c);
        load_strobe_n = 1'b1;
        $display("test strobe done");
    endtask

    task automatic t_phase();
        cmd(3'd2, CMD_LOAD_INPUT, 8'h99);
        cmd(3'b100, CMD_PHASE, 8'h00);
        chk_bit("rising_phase", 1'b1, rising_phase);
        chk_ch(2, 8'h99, 8'h99);
        t_chain(1'b1);
        cmd(3'd0, CMD_CLEAR, 8'hff);
        chk_bit("rising_phase", 1'b1, rising_phase);
        chk_ch(2, 8'h00, 8'h00);
        chk_ch(7, 8'h00, 8'h00);
        cmd(3'd4, CMD_LOAD_INPUT, 8'h44);
        cmd(3'b011, CMD_PHASE, 8'h00);
        chk_bit("rising_phase", 1'b0, rising_phase);
        chk_ch(4, 8'h44, 8'h44);
        $display("test phase done");
    endtask

    task automatic t_shutdown();
        cmd_code_t enders[3] = '{CMD_CLEAR, CMD_LOAD_ALL, CMD_LOAD_BOTH};
        logic [7:0] ei[3] = '{8'h00, 8'h00, 8'h5e};
        cmd(3'd0, CMD_SHUTDOWN, 8'ha5);
        chk("buffer_enable", 16'h00a5, {8'h00, buffer_enable});
        chk_bit("full_powerdown", 1'b0, full_powerdown);
        cmd(3'd0, CMD_SHUTDOWN, 8'h00);
        chk_bit("full_powerdown", 1'b1, full_powerdown);
        cmd(3'd3, CMD_LOAD_INPUT, 8'h01);
        cmd(3'd0, CMD_TRANSFER, 8'h00);
        cmd(3'd0, CMD_PHASE, 8'hff);
        chk("buffer_enable", 16'h0000, {8'h00, buffer_enable});
        chk_bit("full_powerdown", 1'b1, full_powerdown);
        for (int k = 0; k < 3; k++) begin
            cmd(3'd0, CMD_SHUTDOWN, 8'h00);
            cmd(3'd6, enders[k], 8'h5e);
            chk("buffer_enable", 16'h00ff, {8'h00, buffer_enable});
            chk_bit("full_powerdown", 1'b0, full_powerdown);
            chk_ch(6, ei[k], (k == 0) ? 8'h00 : 8'h5e);
        end
        chk_ch(0, 8'h00, 8'h5e);
        $display("test shutdown done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        t_reset();
        t_load_input();
        t_chain(1'b0);
        t_strobe();
        t_phase();
        t_shutdown();
        final_report();
    end

    // about 28 frames of some 150 cycles each
    initial begin
        #2_000_000;
        err_count++;
        final_report();
    end
endmodule
`default_nettype wire
